// ---- core/pin_sync2.sv ----
// pin_sync2: two-flop synchroniser for a group of asynchronous pins
// assumes: single clock aclk, synchronous active-low reset, clock enable
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // pins
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            pin_sync <= '0;
        end else if (ce) begin
            meta <= pin;
            pin_sync <= meta;
        end
    end
endmodule // pin_sync2

// ---- core/sync_select_and_separator.sv ----
// sync_select_and_separator: sync source muxes and composite frame-sync separator
// assumes: sync pins are asynchronous and already polarity-resolved (active high);
// registers are reached over axi4-lite on aclk
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "sync_sep_params.svh"

// Overview of operation
// - ctrl 0x0E bit3 picks line or green sync; 0x0F bit5 picks hold or frame sync.
// - ctrl 0x0E bit0 picks direct frame sync or separator output.
// - ctrl 0x15 bit3 picks channel 0 or channel 1 input set.
// - separator is an 8-bit counter stepping every 200 ns (5 MHz).
// - separator sees only active or inactive level, polarity resolved earlier.
// - count up while sync active, down toward zero after it ends.
// - frame sync present when count climbs past programmable threshold.
// - on detection count clears, then counts up once frame level goes away.
// - frame sync absent only when count during absence reaches threshold.
// - after absence declared, count clears and presence detection restarts.
module sync_select_and_separator #(
    parameter int TICK_CYCLES = `SEP_TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // sync pins, channel 0 and channel 1
    input wire logic [1:0] line_sync_in,
    input wire logic [1:0] green_sync_in,
    input wire logic [1:0] frame_sync_in,
    input wire logic pll_hold_in,
    // selected sync outputs
    output logic line_sync_out,
    output logic pll_hold_out,
    output logic frame_sync_out,
    output logic frame_present,
    output logic chan_sel_out
);
    // registers
    logic [7:0] sync_ctrl;
    logic [7:0] sep_ctrl;
    logic [7:0] threshold;
    logic [7:0] input_ctrl;

    // axi state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // synchronised pins: {hold, frame1, frame0, green1, green0, line1, line0}
    logic [6:0] pins;
    logic [6:0] pins_s;

    // separator state
    sync_sep_pkg::sep_state_t state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt;
    logic tick;

    assign pins = {pll_hold_in, frame_sync_in, green_sync_in, line_sync_in};

    pin_sync2 #(
        .WIDTH(7)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin(pins),
        .pin_sync(pins_s)
    );

    // source selection
    wire chan = input_ctrl[`BIT_CHAN_SEL];
    wire line_c = chan ? pins_s[1] : pins_s[0];
    wire green_c = chan ? pins_s[3] : pins_s[2];
    wire frame_c = chan ? pins_s[5] : pins_s[4];
    wire green_sel = sync_ctrl[`BIT_GREEN_SEL];
    wire sep_sel = sync_ctrl[`BIT_SEP_SEL];
    wire hold_sel = sep_ctrl[`BIT_HOLD_SEL];
    wire line_src = green_sel ? green_c : line_c;
    wire frame_src = sep_sel ? frame_present : frame_c;
    wire hold_src = hold_sel ? frame_sync_out : pins_s[6];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_sync_out <= 1'b0;
            frame_sync_out <= 1'b0;
            pll_hold_out <= 1'b0;
            chan_sel_out <= 1'b0;
        end else if (ce) begin
            line_sync_out <= line_src;
            frame_sync_out <= frame_src;
            pll_hold_out <= hold_src;
            chan_sel_out <= chan;
        end
    end

    // 5 MHz step derived from aclk; one tick every TICK_CYCLES cycles
    assign tick = (tick_cnt == (TICK_CYCLES - 1));

    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && tick)) begin
            tick_cnt <= '0;
        end else if (ce) begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // composite level; polarity was already resolved, so high means active
    wire comp = line_sync_out;
    wire at_max = (count == 8'hff);
    wire at_min = (count == 8'h00);
    wire over_thr = (count > threshold);
    wire reach_thr = (count >= threshold);

    always_comb begin
        next_count = count;
        unique case (state)
            sync_sep_pkg::seek_present: begin
                if (over_thr) begin
                    next_count = 8'h00;
                end else if (comp) begin
                    next_count = at_max ? count : count + 8'h01;
                end else begin
                    next_count = at_min ? count : count - 8'h01;
                end
            end
            sync_sep_pkg::seek_absent: begin
                if (comp || reach_thr) begin
                    next_count = 8'h00;
                end else begin
                    next_count = at_max ? count : count + 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= sync_sep_pkg::seek_present;
            count <= 8'h00;
            frame_present <= 1'b0;
        end else if (ce && tick) begin
            count <= next_count;
            if (state == sync_sep_pkg::seek_present && over_thr) begin
                state <= sync_sep_pkg::seek_absent;
                frame_present <= 1'b1;
            end else if (state == sync_sep_pkg::seek_absent && !comp && reach_thr) begin
                state <= sync_sep_pkg::seek_present;
                frame_present <= 1'b0;
            end
        end
    end

    // axi4-lite slave: address and data taken in either order, one write at a time
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire [7:0] w_idx = aw_addr >> `ADDR_LSB;
    wire [7:0] r_idx = s_axi_araddr >> `ADDR_LSB;
    wire w_go = aw_held && w_held && ce;
    wire w_map = (w_idx == `IDX_SYNC_CTRL) || (w_idx == `IDX_SEP_CTRL) ||
                 (w_idx == `IDX_INPUT_CTRL) || (w_idx == `IDX_SEP_STATUS);
    wire r_map = (r_idx == `IDX_SYNC_CTRL) || (r_idx == `IDX_SEP_CTRL) ||
                 (r_idx == `IDX_INPUT_CTRL) || (r_idx == `IDX_SEP_STATUS);
    wire [31:0] stat_word = {16'h0000, count, 7'h00, frame_present};
    wire [31:0] rd_word =
        (r_idx == `IDX_SYNC_CTRL) ? {24'h000000, sync_ctrl} :
        (r_idx == `IDX_SEP_CTRL) ? {16'h0000, threshold, sep_ctrl} :
        (r_idx == `IDX_INPUT_CTRL) ? {24'h000000, input_ctrl} :
        (r_idx == `IDX_SEP_STATUS) ? stat_word : 32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (w_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (w_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // register writes; status register ignores writes but answers okay
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_ctrl <= `RST_SYNC_CTRL;
            sep_ctrl <= `RST_SEP_CTRL;
            threshold <= `RST_THRESHOLD;
            input_ctrl <= `RST_INPUT_CTRL;
        end else if (w_go) begin
            if (w_idx == `IDX_SYNC_CTRL && w_strb[0]) begin
                sync_ctrl <= w_data[7:0];
            end
            if (w_idx == `IDX_SEP_CTRL && w_strb[0]) begin
                sep_ctrl <= w_data[7:0];
            end
            if (w_idx == `IDX_SEP_CTRL && w_strb[1]) begin
                threshold <= w_data[`THR_MSB:`THR_LSB];
            end
            if (w_idx == `IDX_INPUT_CTRL && w_strb[0]) begin
                input_ctrl <= w_data[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else if (w_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // reads answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= r_map ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_step_present;
        ce && tick && state == sync_sep_pkg::seek_present;
    endsequence

    sequence s_step_absent;
        ce && tick && state == sync_sep_pkg::seek_absent;
    endsequence

    a_line_mux_route: assert property (
        ce |=> line_sync_out == $past(green_sel ? green_c : line_c))
        else $error("line sync mux passed the wrong source");

    a_hold_mux_route: assert property (
        ce && !hold_sel |=> pll_hold_out == $past(pins_s[6]))
        else $error("hold mux passed frame sync while hold selected");

    a_frame_mux_route: assert property (
        ce && sep_sel |=> frame_sync_out == $past(frame_present))
        else $error("frame mux ignored separator selection");

    a_chan_line_pick: assert property (
        ce && !green_sel && chan |=> line_sync_out == $past(pins_s[1]))
        else $error("channel 1 line sync not routed");

    a_count_on_tick: assert property (
        !(ce && tick) |=> $stable(count))
        else $error("separator counter moved without a 5 MHz step");

    a_count_up_sat: assert property (
        s_step_present ##0 (comp && !over_thr) |=> count == ($past(at_max) ?
            8'hff : $past(count) + 8'h01))
        else $error("active sync did not count up with saturation");

    a_present_detect: assert property (
        s_step_present ##0 over_thr |=> frame_present && count == 8'h00 &&
            state == sync_sep_pkg::seek_absent)
        else $error("frame sync presence not declared with cleared count");

    a_absent_detect: assert property (
        s_step_absent ##0 (!comp && reach_thr) |=> !frame_present &&
            count == 8'h00 && state == sync_sep_pkg::seek_present)
        else $error("frame sync absence not declared at threshold");

    a_down_floor: assert property (
        s_step_present ##0 (!comp && at_min && !over_thr) |=> count == 8'h00)
        else $error("counter wrapped below zero");

    a_frame_direct_route: assert property (
        ce && !sep_sel |=> frame_sync_out == $past(frame_c))
        else $error("frame mux did not pass the direct frame sync pin");

    a_chan_out_copy: assert property (
        ce |=> chan_sel_out == $past(chan))
        else $error("channel select output does not follow its control bit");

    a_count_down_step: assert property (
        s_step_present ##0 (!comp && !at_min && !over_thr) |=> count == $past(count) - 8'h01)
        else $error("inactive sync did not count down by one");

    a_absent_hold_zero: assert property (
        s_step_absent ##0 comp |=> count == 8'h00 && frame_present)
        else $error("count not held at zero while frame level stays active");

    a_absent_count_up: assert property (
        s_step_absent ##0 (!comp && !reach_thr) |=> count == $past(count) + 8'h01 &&
            frame_present)
        else $error("absence count did not climb while frame level is gone");

    a_up_ceiling: assert property (
        s_step_present ##0 (comp && at_max && !over_thr) |=> count == 8'hff)
        else $error("counter wrapped above its maximum");

endmodule // sync_select_and_separator

// ---- core/sync_sep_params.svh ----
// sync_sep_params.svh: register indices, field positions, reset values and timing
// assumes: included by the sync block and its package users; definitions only
`ifndef SYNC_SEP_PARAMS_SVH
`define SYNC_SEP_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_SYNC_CTRL 8'h0e
`define IDX_SEP_CTRL 8'h0f
`define IDX_INPUT_CTRL 8'h15
`define IDX_SEP_STATUS 8'h1a
`define ADDR_LSB 2

// field positions
`define BIT_GREEN_SEL 3
`define BIT_SEP_SEL 0
`define BIT_HOLD_SEL 5
`define BIT_CHAN_SEL 3
`define THR_LSB 8
`define THR_MSB 15
`define STAT_PRESENT 0
`define STAT_CNT_LSB 8
`define STAT_CNT_MSB 15

// reset values
`define RST_SYNC_CTRL 8'h00
`define RST_SEP_CTRL 8'h00
`define RST_INPUT_CTRL 8'h00
`define RST_THRESHOLD 8'h20

// timing: separator count period and system clock period
`define SEP_PERIOD_NS 200
`define CLK_PERIOD_NS 5
`define SEP_TICK_CYCLES (`SEP_PERIOD_NS / `CLK_PERIOD_NS)

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- core/sync_sep_pkg.sv ----
// sync_sep_pkg: types shared by the sync select and separator block
// assumes: constants come from sync_sep_params.svh
package sync_sep_pkg;
    typedef enum logic [0:0] {
        seek_present,
        seek_absent
    } sep_state_t;
endpackage

// ---- verification/sync_select_and_separator_tb_top.sv ----
// sync_select_and_separator_tb_top: self-checking bench for sync muxes and separator
// assumes: design and source model compiled first; ce held high except while t_clock_enable drives it low
`timescale 1ns/1ps
`include "sync_sep_params.svh"
module sync_select_and_separator_tb_top;
    localparam logic [7:0] A_SYNC = 8'(`IDX_SYNC_CTRL << `ADDR_LSB);
    localparam logic [7:0] A_SEP = 8'(`IDX_SEP_CTRL << `ADDR_LSB);
    localparam logic [7:0] A_IN = 8'(`IDX_INPUT_CTRL << `ADDR_LSB);
    localparam logic [7:0] A_STAT = 8'(`IDX_SEP_STATUS << `ADDR_LSB);
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, line_sync_in, green_sync_in, frame_sync_in;
    logic pll_hold_in, line_sync_out, pll_hold_out, frame_sync_out, frame_present;
    logic chan_sel_out;
    logic [6:0] pat = 7'h00;
    logic run = 1'b0, vs_on = 1'b0;
    int n_fail = 0, comparisons = 0;

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    sync_select_and_separator #(.TICK_CYCLES(2)) u_sync_select_and_separator (
        .aclk, .aresetn, .ce,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .line_sync_in, .green_sync_in, .frame_sync_in, .pll_hold_in,
        .line_sync_out, .pll_hold_out, .frame_sync_out, .frame_present, .chan_sel_out
    );

    sync_source_model u_sync_source_model (
        .aclk, .pat, .run, .vs_on,
        .line_sync_in, .green_sync_in, .frame_sync_in, .pll_hold_in
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        if (n_fail == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // each channel drops its valid once taken; the wait ends on the response
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        check("rdata", s_axi_rdata, ed);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic t_reset_values;
        axi_rd(A_SYNC, 32'h0, `RESP_OKAY);
        axi_rd(A_SEP, {16'h0, `RST_THRESHOLD, 8'h00}, `RESP_OKAY);
        axi_rd(A_IN, 32'h0, `RESP_OKAY);
        axi_rd(A_STAT, 32'h0, `RESP_OKAY);
        axi_rd(8'h00, 32'h0, `RESP_SLVERR);
        axi_wr(8'h00, 32'hffff_ffff, `RESP_SLVERR);
    endtask

    // rows: sync ctrl, sep ctrl, input ctrl, pins, {line, hold, frame, chan}
    task automatic t_mux_routing;
        logic [31:0] sc [5] = '{32'h0, 32'h8, 32'h8, 32'h0, 32'h0};
        logic [31:0] sp [5] = '{32'h2000, 32'h2000, 32'h2000, 32'h2020, 32'h2000};
        logic [31:0] ic [5] = '{32'h0, 32'h0, 32'h8, 32'h8, 32'h0};
        logic [6:0] pt [5] = '{7'h01, 7'h06, 7'h05, 7'h20, 7'h40};
        logic [3:0] ex [5] = '{4'h8, 4'h8, 4'h1, 4'h7, 4'h4};
        for (int i = 0; i < 5; i++) begin
            axi_wr(A_SYNC, sc[i], `RESP_OKAY);
            axi_wr(A_SEP, sp[i], `RESP_OKAY);
            axi_wr(A_IN, ic[i], `RESP_OKAY);
            pat <= pt[i];
            // hold fed from frame output sits one flop behind the others
            repeat (6) @(posedge aclk);
            check("mux_out", {28'h0, line_sync_out, pll_hold_out, frame_sync_out,
                chan_sel_out}, {28'h0, ex[i]});
        end
    endtask

    // with the enable low the pins must not reach the outputs
    task automatic t_clock_enable;
        ce <= 1'b0;
        pat <= 7'h01;
        repeat (6) @(posedge aclk);
        check("ce_frozen", {30'h0, line_sync_out, pll_hold_out}, 32'h1);
        ce <= 1'b1;
        repeat (6) @(posedge aclk);
        check("ce_running", {30'h0, line_sync_out, pll_hold_out}, 32'h2);
        pat <= 7'h00;
    endtask

    task automatic t_separator;
        int n;
        logic hit;
        hit = 1'b0;
        pat <= 7'h00;
        axi_wr(A_SYNC, 32'h9, `RESP_OKAY);
        axi_wr(A_SEP, 32'h0a00, `RESP_OKAY);
        run <= 1'b1;
        repeat (400) begin
            @(posedge aclk);
            hit = hit | frame_present;
        end
        check("line_reject", {31'h0, hit}, 32'h0);
        vs_on <= 1'b1;
        n = 0;
        while (frame_present !== 1'b1 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        check("detect_delay", {31'h0, n >= 14 && n <= 30}, 32'h1);
        repeat (2) @(posedge aclk);
        check("frame_out", {31'h0, frame_sync_out}, 32'h1);
        axi_rd(A_STAT, 32'h1, `RESP_OKAY);
        vs_on <= 1'b0;
        run <= 1'b0;
        n = 0;
        while (frame_present !== 1'b0 && n < 200) begin
            @(posedge aclk);
            n++;
        end
        check("absent_delay", {31'h0, n >= 18 && n <= 28}, 32'h1);
        axi_rd(A_STAT, 32'h0, `RESP_OKAY);
    endtask

    // a threshold of 255 can never be passed, so the count must pin at 255
    task automatic t_saturation;
        axi_wr(A_SEP, 32'hff00, `RESP_OKAY);
        vs_on <= 1'b1;
        repeat (600) @(posedge aclk);
        axi_rd(A_STAT, 32'hff00, `RESP_OKAY);
        vs_on <= 1'b0;
        repeat (600) @(posedge aclk);
        axi_rd(A_STAT, 32'h0, `RESP_OKAY);
    endtask

    // reset in mid-run restores controls; a low-byte strobe spares the threshold
    task automatic t_mid_reset;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(A_SYNC, 32'h0, `RESP_OKAY);
        axi_rd(A_SEP, {16'h0, `RST_THRESHOLD, 8'h00}, `RESP_OKAY);
        s_axi_wstrb <= 4'h1;
        axi_wr(A_SEP, 32'hff20, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi_rd(A_SEP, {16'h0, `RST_THRESHOLD, 8'h20}, `RESP_OKAY);
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset_values;
        t_mux_routing;
        t_clock_enable;
        t_separator;
        t_saturation;
        t_mid_reset;
        test_done;
    end

    initial begin
        repeat (10000) @(posedge aclk);
        n_fail++;
        test_done;
    end
endmodule // sync_select_and_separator_tb_top

// ---- verification/sync_source_model.sv ----
// sync_source_model: graphics source that drives the sync pins
// assumes: controlled by the bench on aclk; composite sync rides on channel 0 green
`timescale 1ns/1ps
module sync_source_model (
    // clock
    input wire logic aclk,
    // control from the bench
    input wire logic [6:0] pat,
    input wire logic run,
    input wire logic vs_on,
    // sync pins
    output logic [1:0] line_sync_in,
    output logic [1:0] green_sync_in,
    output logic [1:0] frame_sync_in,
    output logic pll_hold_in
);
    logic [4:0] phase = 5'h00;
    logic comp;
    // 6 of 20 cycles high: a line pulse far shorter than any frame pulse
    always_ff @(posedge aclk) begin
        phase <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
    end
    assign comp = vs_on | (run & (phase < 5'h06));
    assign line_sync_in = pat[1:0];
    assign green_sync_in = pat[3:2] | {1'b0, comp};
    assign frame_sync_in = pat[5:4];
    assign pll_hold_in = pat[6];
endmodule // sync_source_model
